// [common/iosd_pkg.sv]
// Package: address map, field positions and access codes for the I/O space decoder
package iosd_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  // Direct I/O window and data-space mapping
  localparam logic [7:0] IO_DIRECT_MAX = 8'h3f;
  localparam logic [7:0] IO_BIT_MAX = 8'h1f;
  localparam logic [7:0] IO_DATA_OFFSET = 8'h20;
  localparam logic [7:0] EXT_LO = 8'h60;
  // Register offsets (clock_prescale_ctl is a direct I/O address)
  localparam logic [7:0] OFS_CLOCK_PRESCALE_CTL = 8'h02;
  localparam logic [7:0] OFS_CLOCK_SWITCH_CTL_STATUS = 8'h62;
  localparam logic [7:0] OFS_CLOCK_SOURCE_SELECT = 8'h63;
  localparam logic [7:0] OFS_POWER_REDUCTION_CTL = 8'h64;
  localparam logic [7:0] OFS_OSCILLATOR_TRIM = 8'h66;
  localparam logic [7:0] OFS_PIN_CHANGE_IRQ_ENABLE = 8'h68;
  localparam logic [7:0] OFS_EXT_IRQ_SENSE_CTL = 8'h69;
  localparam logic [7:0] OFS_PIN_CHANGE_MASK_LO = 8'h6b;
  localparam logic [7:0] OFS_PIN_CHANGE_MASK_HI = 8'h6c;
  localparam logic [7:0] OFS_COUNTER8_IRQ_MASK = 8'h6e;
  localparam logic [7:0] OFS_COUNTER16_IRQ_MASK = 8'h6f;
  localparam logic [7:0] OFS_ANALOG_MISC_CTL = 8'h77;
  localparam logic [7:0] OFS_CONV_RESULT_LOW = 8'h78;
  localparam logic [7:0] OFS_CONV_RESULT_HIGH = 8'h79;
  localparam logic [7:0] OFS_CONV_CTL_STATUS_A = 8'h7a;
  localparam logic [7:0] OFS_CONV_CTL_STATUS_B = 8'h7b;
  localparam logic [7:0] OFS_CONV_INPUT_SELECT = 8'h7c;
  localparam logic [7:0] OFS_DIGITAL_INPUT_DISABLE_0 = 8'h7e;
  localparam logic [7:0] OFS_DIGITAL_INPUT_DISABLE_1 = 8'h7f;
  localparam logic [7:0] OFS_COUNTER16_CTL_A = 8'h80;
  localparam logic [7:0] OFS_COUNTER16_CTL_B = 8'h81;
  // Implemented-bit masks; other bits store nothing and read zero, except bit 4 clock-ready and done flags
  localparam logic [7:0] MSK_CLOCK_PRESCALE_CTL = 8'hff;
  localparam logic [7:0] MSK_CLOCK_SWITCH_CTL_STATUS = 8'h8f;
  localparam logic [7:0] MSK_CLOCK_SOURCE_SELECT = 8'h7f;
  localparam logic [7:0] MSK_POWER_REDUCTION_CTL = 8'h3f;
  localparam logic [7:0] MSK_OSCILLATOR_TRIM = 8'hff;
  localparam logic [7:0] MSK_PIN_CHANGE_IRQ_ENABLE = 8'h03;
  localparam logic [7:0] MSK_EXT_IRQ_SENSE_CTL = 8'h0f;
  localparam logic [7:0] MSK_PIN_CHANGE_MASK = 8'hff;
  localparam logic [7:0] MSK_COUNTER8_IRQ_MASK = 8'h03;
  localparam logic [7:0] MSK_COUNTER16_IRQ_MASK = 8'h27;
  localparam logic [7:0] MSK_ANALOG_MISC_CTL = 8'h07;
  localparam logic [7:0] MSK_CONV_CTL_STATUS_A = 8'hef;
  localparam logic [7:0] MSK_CONV_CTL_STATUS_B = 8'hf7;
  localparam logic [7:0] MSK_CONV_INPUT_SELECT = 8'hff;
  localparam logic [7:0] MSK_DIGITAL_INPUT_DISABLE_0 = 8'hff;
  localparam logic [7:0] MSK_DIGITAL_INPUT_DISABLE_1 = 8'h07;
  localparam logic [7:0] MSK_COUNTER16_CTL_A = 8'hf3;
  localparam logic [7:0] MSK_COUNTER16_CTL_B = 8'hdf;
  // Field positions
  localparam int unsigned BIT_CLOCK_READY = 4;
  localparam int unsigned BIT_CONV_START = 6;
  localparam int unsigned BIT_CONV_DONE_FLAG = 4;
  localparam int unsigned BIT_RESULT_LEFT_ADJ = 5;
  localparam int unsigned CONV_RES_W = 10;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  // Access kinds issued by the core
  typedef enum logic [2:0] {
    IOSD_OP_NONE = 3'h0,
    IOSD_OP_DATA_LOAD = 3'h1,
    IOSD_OP_DATA_STORE = 3'h2,
    IOSD_OP_IO_IN = 3'h3,
    IOSD_OP_IO_OUT = 3'h4,
    IOSD_OP_SET_BIT = 3'h5,
    IOSD_OP_CLEAR_BIT = 3'h6,
    IOSD_OP_TEST_BIT = 3'h7
  } iosd_op_t;
endpackage : iosd_pkg

// [hw/iosd_decode.sv]
// I/O register space decoder with the clock, power, converter and counter control registers
// Notes on behaviour
// - Bit set and clear on 0x00..0x1F
// - Bit test on 0x00..0x1F
// - Some status flags clear on written one
// - Bit ops touch only the addressed bit
// - Direct I/O uses addresses 0x00..0x3F only
// - Data-space address is I/O address plus 0x20
// - 0x60..0xFF reachable only by data-space access
// - Nonvolatile address bits above top are ignored
`timescale 1ns/1ps
module iosd_decode #(
  parameter int unsigned NV_ADDR_TOP_BIT = 8
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire iosd_pkg::iosd_op_t op,
  input wire logic [iosd_pkg::ADDR_W-1:0] addr,
  input wire logic [2:0] bit_sel,
  input wire logic [iosd_pkg::DATA_W-1:0] wdata,
  input wire logic [iosd_pkg::CONV_RES_W-1:0] conv_result,
  input wire logic conv_done,
  input wire logic clock_ready,
  input wire logic [15:0] nv_addr_in,
  output logic [iosd_pkg::DATA_W-1:0] rdata,
  output logic bit_value,
  output logic ack,
  output logic [15:0] nv_addr_eff,
  output logic [7:0] clock_prescale_ctl,
  output logic [7:0] clock_source_select,
  output logic [7:0] power_reduction_ctl,
  output logic [7:0] oscillator_trim,
  output logic [7:0] conv_ctl_a,
  output logic [7:0] conv_input_select,
  output logic [7:0] counter16_ctl_a,
  output logic [7:0] counter16_ctl_b
);
  import iosd_pkg::*;

  localparam int unsigned NREG = 20;
  localparam logic [7:0] OFS [NREG] = '{
    OFS_CLOCK_PRESCALE_CTL, OFS_CLOCK_SWITCH_CTL_STATUS, OFS_CLOCK_SOURCE_SELECT,
    OFS_POWER_REDUCTION_CTL, OFS_OSCILLATOR_TRIM, OFS_PIN_CHANGE_IRQ_ENABLE,
    OFS_EXT_IRQ_SENSE_CTL, OFS_PIN_CHANGE_MASK_LO, OFS_PIN_CHANGE_MASK_HI,
    OFS_COUNTER8_IRQ_MASK, OFS_COUNTER16_IRQ_MASK, OFS_ANALOG_MISC_CTL,
    OFS_CONV_CTL_STATUS_A, OFS_CONV_CTL_STATUS_B, OFS_CONV_INPUT_SELECT,
    OFS_DIGITAL_INPUT_DISABLE_0, OFS_DIGITAL_INPUT_DISABLE_1, OFS_COUNTER16_CTL_A,
    OFS_COUNTER16_CTL_B, OFS_CONV_RESULT_LOW
  };
  localparam logic [7:0] MSK [NREG] = '{
    MSK_CLOCK_PRESCALE_CTL, MSK_CLOCK_SWITCH_CTL_STATUS, MSK_CLOCK_SOURCE_SELECT,
    MSK_POWER_REDUCTION_CTL, MSK_OSCILLATOR_TRIM, MSK_PIN_CHANGE_IRQ_ENABLE,
    MSK_EXT_IRQ_SENSE_CTL, MSK_PIN_CHANGE_MASK, MSK_PIN_CHANGE_MASK,
    MSK_COUNTER8_IRQ_MASK, MSK_COUNTER16_IRQ_MASK, MSK_ANALOG_MISC_CTL,
    MSK_CONV_CTL_STATUS_A, MSK_CONV_CTL_STATUS_B, MSK_CONV_INPUT_SELECT,
    MSK_DIGITAL_INPUT_DISABLE_0, MSK_DIGITAL_INPUT_DISABLE_1, MSK_COUNTER16_CTL_A,
    MSK_COUNTER16_CTL_B, 8'h00
  };
  localparam int unsigned IX_CLKSW = 1;
  localparam int unsigned IX_CONV_A = 12;
  localparam int unsigned IX_CONV_MUX = 14;
  localparam int unsigned NSTORE = 19;
  localparam logic [7:0] PSC_DATA_ADDR = 8'(OFS_CLOCK_PRESCALE_CTL + IO_DATA_OFFSET);

  // Maps an access to a data-space address; direct I/O adds the fixed offset
  function automatic logic [8:0] space_addr(input iosd_op_t o, input logic [7:0] a);
    logic direct;
    direct = (o == IOSD_OP_IO_IN) || (o == IOSD_OP_IO_OUT) || (o == IOSD_OP_SET_BIT) ||
             (o == IOSD_OP_CLEAR_BIT) || (o == IOSD_OP_TEST_BIT);
    if (direct) begin
      space_addr = {1'b0, a} + {1'b0, IO_DATA_OFFSET};
    end else begin
      space_addr = {1'b0, a};
    end
  endfunction : space_addr

  logic [7:0] regs_reg [NSTORE];
  logic [7:0] regs_next [NSTORE];
  logic conv_done_s1_reg;
  logic conv_done_s2_reg;
  logic conv_done_d_reg;
  logic clk_rdy_s1_reg;
  logic clk_rdy_s2_reg;
  logic [CONV_RES_W-1:0] res_s1_reg;
  logic [CONV_RES_W-1:0] res_s2_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic bit_value_reg;
  logic bit_value_next;
  logic ack_reg;
  logic ack_next;
  logic [15:0] nv_addr_reg;
  logic [15:0] nv_addr_next;

  logic direct_op;
  logic bit_op;
  logic legal;
  logic [8:0] daddr;
  logic [7:0] daddr8;
  logic [NREG-1:0] hit;
  logic [7:0] read_val;
  logic [7:0] res_lo;
  logic [7:0] res_hi;
  logic done_rise;

  always_comb begin
    direct_op = (op == IOSD_OP_IO_IN) || (op == IOSD_OP_IO_OUT) ||
                (op == IOSD_OP_SET_BIT) || (op == IOSD_OP_CLEAR_BIT) ||
                (op == IOSD_OP_TEST_BIT);
    bit_op = (op == IOSD_OP_SET_BIT) || (op == IOSD_OP_CLEAR_BIT) || (op == IOSD_OP_TEST_BIT);
    legal = 1'b1;
    if (direct_op && (addr > IO_DIRECT_MAX)) begin
      legal = 1'b0;
    end
    if (bit_op && (addr > IO_BIT_MAX)) begin
      legal = 1'b0;
    end
    daddr = space_addr(op, addr);
    daddr8 = daddr[7:0];
  end

  // Address hit per register; the prescaler is also seen at its data-space alias
  generate
    for (genvar g = 0; g < NREG; g++) begin : g_hit
      if (g == 0) begin : g_io
        assign hit[g] = legal && (op != IOSD_OP_NONE) && !daddr[8] &&
                        (daddr8 == PSC_DATA_ADDR);
      end else begin : g_ext
        assign hit[g] = legal && !direct_op && (op != IOSD_OP_NONE) &&
                        !daddr[8] && (daddr8 == OFS[g]);
      end
    end
  endgenerate

  always_comb begin
    res_lo = regs_reg[IX_CONV_MUX][BIT_RESULT_LEFT_ADJ] ? {res_s2_reg[1:0], 6'h00}
                                                        : res_s2_reg[7:0];
    res_hi = regs_reg[IX_CONV_MUX][BIT_RESULT_LEFT_ADJ] ? res_s2_reg[9:2]
                                                        : {6'h00, res_s2_reg[9:8]};
    read_val = 8'h00;
    for (int i = 0; i < NSTORE; i++) begin
      if (hit[i]) begin
        read_val = regs_reg[i] & MSK[i];
      end
    end
    if (hit[IX_CLKSW]) begin
      read_val[BIT_CLOCK_READY] = clk_rdy_s2_reg;
    end
    if (hit[IX_CONV_A]) begin
      read_val[BIT_CONV_DONE_FLAG] = regs_reg[IX_CONV_A][BIT_CONV_DONE_FLAG];
    end
    if (hit[NSTORE]) begin
      read_val = res_lo;
    end
    if (legal && !direct_op && (daddr == {1'b0, OFS_CONV_RESULT_HIGH})) begin
      read_val = res_hi;
    end
  end

  assign done_rise = conv_done_s2_reg && !conv_done_d_reg;

  always_comb begin
    for (int i = 0; i < NSTORE; i++) begin
      regs_next[i] = regs_reg[i];
      if (hit[i]) begin
        case (op)
          IOSD_OP_DATA_STORE, IOSD_OP_IO_OUT: regs_next[i] = wdata & MSK[i];
          IOSD_OP_SET_BIT: regs_next[i][bit_sel] = MSK[i][bit_sel];
          IOSD_OP_CLEAR_BIT: regs_next[i][bit_sel] = 1'b0;
          default: regs_next[i] = regs_reg[i];
        endcase
      end
    end
    // Done flag: written one clears it, zero keeps it, a new event wins
    regs_next[IX_CONV_A][BIT_CONV_DONE_FLAG] = regs_reg[IX_CONV_A][BIT_CONV_DONE_FLAG];
    if (hit[IX_CONV_A] && ((op == IOSD_OP_DATA_STORE) || (op == IOSD_OP_IO_OUT)) &&
        wdata[BIT_CONV_DONE_FLAG]) begin
      regs_next[IX_CONV_A][BIT_CONV_DONE_FLAG] = 1'b0;
    end
    if (done_rise) begin
      regs_next[IX_CONV_A][BIT_CONV_DONE_FLAG] = 1'b1;
      regs_next[IX_CONV_A][BIT_CONV_START] = 1'b0;
    end
    regs_next[IX_CLKSW][BIT_CLOCK_READY] = 1'b0;
  end

  always_comb begin
    rdata_next = rdata_reg;
    bit_value_next = bit_value_reg;
    ack_next = (op != IOSD_OP_NONE);
    if ((op == IOSD_OP_DATA_LOAD) || (op == IOSD_OP_IO_IN)) begin
      rdata_next = read_val;
    end
    if (op == IOSD_OP_TEST_BIT) begin
      bit_value_next = legal ? read_val[bit_sel] : 1'b0;
    end
    nv_addr_next = nv_addr_in & 16'((32'h1 << (NV_ADDR_TOP_BIT + 1)) - 1);
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NSTORE; i++) begin
        regs_reg[i] <= RESET_VALUE;
      end
      conv_done_s1_reg <= 1'b0;
      conv_done_s2_reg <= 1'b0;
      conv_done_d_reg <= 1'b0;
      clk_rdy_s1_reg <= 1'b0;
      clk_rdy_s2_reg <= 1'b0;
      res_s1_reg <= '0;
      res_s2_reg <= '0;
      rdata_reg <= 8'h00;
      bit_value_reg <= 1'b0;
      ack_reg <= 1'b0;
      nv_addr_reg <= 16'h0000;
    end else begin
      regs_reg <= regs_next;
      conv_done_s1_reg <= conv_done;
      conv_done_s2_reg <= conv_done_s1_reg;
      conv_done_d_reg <= conv_done_s2_reg;
      clk_rdy_s1_reg <= clock_ready;
      clk_rdy_s2_reg <= clk_rdy_s1_reg;
      res_s1_reg <= conv_result;
      res_s2_reg <= res_s1_reg;
      rdata_reg <= rdata_next;
      bit_value_reg <= bit_value_next;
      ack_reg <= ack_next;
      nv_addr_reg <= nv_addr_next;
    end
  end

  assign rdata = rdata_reg;
  assign bit_value = bit_value_reg;
  assign ack = ack_reg;
  assign nv_addr_eff = nv_addr_reg;
  assign clock_prescale_ctl = regs_reg[0];
  assign clock_source_select = regs_reg[2];
  assign power_reduction_ctl = regs_reg[3];
  assign oscillator_trim = regs_reg[4];
  assign conv_ctl_a = regs_reg[IX_CONV_A];
  assign conv_input_select = regs_reg[IX_CONV_MUX];
  assign counter16_ctl_a = regs_reg[17];
  assign counter16_ctl_b = regs_reg[18];
endmodule : iosd_decode

// [dv/iosd_decode_properties.sv]
// Checker for the I/O space decoder ports
`timescale 1ns/1ps
module iosd_decode_properties #(
  parameter int unsigned NV_ADDR_TOP_BIT = 8
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire iosd_pkg::iosd_op_t op,
  input wire logic [7:0] addr,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] wdata,
  input wire logic [15:0] nv_addr_in,
  input wire logic [7:0] rdata,
  input wire logic bit_value,
  input wire logic ack,
  input wire logic [15:0] nv_addr_eff,
  input wire logic [7:0] clock_prescale_ctl,
  input wire logic [7:0] power_reduction_ctl
);
  import iosd_pkg::*;
  localparam logic [15:0] NVM = 16'((32'h1 << (NV_ADDR_TOP_BIT + 1)) - 1);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_ack_after_op: assert property (op != IOSD_OP_NONE |=> ack) else $error("no ack");
  a_no_idle_ack: assert property (op == IOSD_OP_NONE |=> !ack) else $error("stray ack");
  a_data_alias: assert property (op == IOSD_OP_DATA_STORE && addr == 8'h22
    |=> clock_prescale_ctl == $past(wdata)) else $error("data-space alias");
  a_store_ext_reg: assert property (op == IOSD_OP_DATA_STORE && addr == 8'h64
    |=> power_reduction_ctl == ($past(wdata) & MSK_POWER_REDUCTION_CTL)) else $error("store");
  a_out_refused: assert property (op == IOSD_OP_IO_OUT && addr > 8'h3f
    |=> $stable(power_reduction_ctl) && $stable(clock_prescale_ctl)) else $error("io out");
  a_set_one_bit: assert property (op == IOSD_OP_SET_BIT && addr == 8'h02
    |=> clock_prescale_ctl == ($past(clock_prescale_ctl) | (8'h01 << $past(bit_sel))))
    else $error("set bit");
  a_clear_one_bit: assert property (op == IOSD_OP_CLEAR_BIT && addr == 8'h02
    |=> clock_prescale_ctl == ($past(clock_prescale_ctl) & ~(8'h01 << $past(bit_sel))))
    else $error("clear bit");
  a_test_bit_val: assert property (op == IOSD_OP_TEST_BIT && addr == 8'h02
    |=> bit_value == $past(clock_prescale_ctl[bit_sel])) else $error("test bit");
  a_io_in_read: assert property (op == IOSD_OP_IO_IN && addr == 8'h02
    |=> rdata == $past(clock_prescale_ctl)) else $error("io in");
  a_reserved_zero: assert property (op == IOSD_OP_DATA_LOAD && addr == 8'h65
    |=> rdata == 8'h00) else $error("reserved read");
  a_nv_masked: assert property (1'b1 |=> nv_addr_eff == ($past(nv_addr_in) & NVM))
    else $error("nv mask");
  c_set_bit: cover property (op == IOSD_OP_SET_BIT ##1 ack);
  c_store: cover property (op == IOSD_OP_DATA_STORE ##1 ack);
  c_test_bit: cover property (op == IOSD_OP_TEST_BIT ##1 bit_value);
endmodule : iosd_decode_properties

// [dv/iosd_core_model.sv]
// Core model issuing one access per call
`timescale 1ns/1ps
module iosd_core_model (
  input wire logic ref_clk,
  output iosd_pkg::iosd_op_t op,
  output logic [7:0] addr,
  output logic [2:0] bit_sel,
  output logic [7:0] wdata
);
  import iosd_pkg::*;
  initial begin
    op = IOSD_OP_NONE;
    addr = 8'h00;
    bit_sel = 3'h0;
    wdata = 8'h00;
  end
  // Store data is driven unmasked; the decoder masks it to implemented bits
  task automatic xfer(input iosd_op_t o, input logic [7:0] a, input logic [2:0] b,
                      input logic [7:0] d);
    @(negedge ref_clk);
    op = o;
    addr = a;
    bit_sel = b;
    wdata = d;
    @(negedge ref_clk);
    // Released op, addr and wdata do not keep the last value; bit_sel does
    op = IOSD_OP_NONE;
    addr = ~a;
    wdata = ~d;
  endtask : xfer
endmodule : iosd_core_model

// [dv/io_space_register_decode_bench.sv]
// Testbench for the I/O space decoder
`timescale 1ns/1ps
module io_space_register_decode_bench;
  import iosd_pkg::*;
  localparam int unsigned NV = 8;
  logic ref_clk, reset_n, bv, ack, conv_done, clock_ready;
  iosd_op_t op;
  logic [7:0] addr, wdata, rdata, psc, pwr, css, osc, cva, cim, c1a, c1b;
  logic [2:0] bit_sel;
  logic [9:0] conv_result;
  logic [15:0] nv_in, nv_eff;
  int errors, check_count;
  logic [7:0] ra [18] = '{8'h62, 8'h63, 8'h64, 8'h66, 8'h68, 8'h69, 8'h6b, 8'h6c, 8'h6e,
    8'h6f, 8'h77, 8'h7a, 8'h7b, 8'h7c, 8'h7e, 8'h7f, 8'h80, 8'h81};
  logic [7:0] rm [18] = '{MSK_CLOCK_SWITCH_CTL_STATUS, MSK_CLOCK_SOURCE_SELECT,
    MSK_POWER_REDUCTION_CTL, MSK_OSCILLATOR_TRIM, MSK_PIN_CHANGE_IRQ_ENABLE,
    MSK_EXT_IRQ_SENSE_CTL, MSK_PIN_CHANGE_MASK, MSK_PIN_CHANGE_MASK, MSK_COUNTER8_IRQ_MASK,
    MSK_COUNTER16_IRQ_MASK, MSK_ANALOG_MISC_CTL, MSK_CONV_CTL_STATUS_A, MSK_CONV_CTL_STATUS_B,
    MSK_CONV_INPUT_SELECT, MSK_DIGITAL_INPUT_DISABLE_0, MSK_DIGITAL_INPUT_DISABLE_1,
    MSK_COUNTER16_CTL_A, MSK_COUNTER16_CTL_B};
  logic [7:0] rsv [4] = '{8'h65, 8'h67, 8'h7d, 8'h90};
  iosd_decode #(.NV_ADDR_TOP_BIT(NV)) iosd_decode_inst (.ref_clk(ref_clk), .reset_n(reset_n),
    .op(op), .addr(addr), .bit_sel(bit_sel), .wdata(wdata), .conv_result(conv_result),
    .conv_done(conv_done), .clock_ready(clock_ready), .nv_addr_in(nv_in), .rdata(rdata),
    .bit_value(bv), .ack(ack), .nv_addr_eff(nv_eff), .clock_prescale_ctl(psc),
    .clock_source_select(css), .power_reduction_ctl(pwr), .oscillator_trim(osc),
    .conv_ctl_a(cva), .conv_input_select(cim), .counter16_ctl_a(c1a),
    .counter16_ctl_b(c1b));
  iosd_core_model iosd_core_model_inst (.ref_clk(ref_clk), .op(op), .addr(addr),
    .bit_sel(bit_sel), .wdata(wdata));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic io(input iosd_op_t o, input logic [7:0] a, input logic [2:0] b,
                    input logic [7:0] d);
    iosd_core_model_inst.xfer(o, a, b, d);
    chk({7'h00, ack}, 8'h01);
  endtask : io
  task automatic data_store(input logic [7:0] a, input logic [7:0] d);
    io(IOSD_OP_DATA_STORE, a, 3'h0, d);
  endtask : data_store
  task automatic data_load(input logic [7:0] a, input logic [7:0] exp);
    io(IOSD_OP_DATA_LOAD, a, 3'h0, 8'h00);
    chk(rdata, exp);
  endtask : data_load
  task automatic tally_and_finish();
    if (errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    errors++;
    tally_and_finish();
  end
  initial begin
    reset_n = 1'b0;
    conv_result = 10'h2a5;
    conv_done = 1'b0;
    clock_ready = 1'b0;
    nv_in = 16'h0000;
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    reset_n = 1'b1;
    foreach (ra[i]) data_load(ra[i], RESET_VALUE);
    foreach (ra[i]) data_store(ra[i], rm[i]);
    chk(css, MSK_CLOCK_SOURCE_SELECT);
    chk(pwr, MSK_POWER_REDUCTION_CTL);
    chk(osc, MSK_OSCILLATOR_TRIM);
    chk(cva, MSK_CONV_CTL_STATUS_A);
    chk(cim, MSK_CONV_INPUT_SELECT);
    chk(c1a, MSK_COUNTER16_CTL_A);
    chk(c1b, MSK_COUNTER16_CTL_B);
    foreach (ra[i]) data_load(ra[i], rm[i]);
    foreach (ra[i]) data_store(ra[i], 8'h00);
    foreach (rsv[i]) data_load(rsv[i], 8'h00);
    io(IOSD_OP_IO_OUT, 8'h02, 3'h0, 8'ha5);
    io(IOSD_OP_IO_IN, 8'h02, 3'h0, 8'h00);
    chk(rdata, 8'ha5);
    io(IOSD_OP_SET_BIT, 8'h02, 3'h6, 8'h00);
    chk(psc, 8'he5);
    io(IOSD_OP_CLEAR_BIT, 8'h02, 3'h0, 8'h00);
    chk(psc, 8'he4);
    for (int i = 0; i < 8; i++) begin
      io(IOSD_OP_TEST_BIT, 8'h02, 3'(i), 8'h00);
      chk({7'h00, bv}, (8'he4 >> i) & 8'h01);
    end
    data_store(8'h22, 8'h3c);
    chk(psc, 8'h3c);
    data_load(8'h22, 8'h3c);
    io(IOSD_OP_IO_OUT, 8'h44, 3'h0, 8'h15);
    chk(pwr, 8'h00);
    io(IOSD_OP_IO_IN, 8'h44, 3'h0, 8'h00);
    chk(rdata, 8'h00);
    io(IOSD_OP_TEST_BIT, 8'h22, 3'h2, 8'h00);
    chk({7'h00, bv}, 8'h00);
    conv_done = 1'b1;
    @(negedge ref_clk);
    // Clear lands on the edge that sets the flag
    data_store(8'h7a, 8'h10);
    chk(cva, 8'h10);
    data_load(8'h7a, 8'h10);
    data_store(8'h7a, 8'h00);
    data_load(8'h7a, 8'h10);
    data_store(8'h7a, 8'h10);
    data_load(8'h7a, 8'h00);
    data_load(8'h78, 8'ha5);
    data_load(8'h79, 8'h02);
    data_store(8'h7c, 8'h20);
    data_load(8'h79, 8'ha9);
    data_load(8'h78, 8'h40);
    clock_ready = 1'b1;
    repeat (3) @(negedge ref_clk);
    data_load(8'h62, 8'h10);
    nv_in = 16'hffff;
    repeat (2) @(negedge ref_clk);
    chk(nv_eff[15:8], 8'(((32'h1 << (NV + 1)) - 1) >> 8));
    chk(nv_eff[7:0], 8'hff);
    tally_and_finish();
  end
endmodule : io_space_register_decode_bench
bind iosd_decode iosd_decode_properties #(.NV_ADDR_TOP_BIT(NV_ADDR_TOP_BIT)) props_inst (
  .ref_clk(ref_clk), .reset_n(reset_n), .op(op), .addr(addr), .bit_sel(bit_sel),
  .wdata(wdata), .nv_addr_in(nv_addr_in), .rdata(rdata), .bit_value(bit_value), .ack(ack),
  .nv_addr_eff(nv_addr_eff), .clock_prescale_ctl(clock_prescale_ctl),
  .power_reduction_ctl(power_reduction_ctl));
